// [rtl/rcv_top.sv]
// Reset-cause register, vector table selection and interrupt folding
`timescale 1ns/1ps
//
// Contract
// RULE1: cause register readable after any reset
// RULE2: software clears flags after reading them
// RULE3: software may set or clear each flag
// RULE4: trap, illegal, mismatch, soft flags; cleared power/brown
// RULE5: watchdog flag set on expiry, cleared several ways
// RULE6: sleep, idle flags; pin flag cleared by power-on
// RULE7: power-on sets bits 0,1; brown-out sets bit 1
// RULE8: long master-clear low pulse sets pin flag
// RULE9: all requests fold into one core request
// RULE10: seven levels, fixed order within a level
// RULE11: fixed entry and return cycle counts
// RULE12: primary table starts at 000004h, 24-bit entries
// RULE13: 126 entries, 8 traps then 118 sources
// RULE14: lower vector address means higher priority
// RULE15: 21 sources and four traps implemented
// RULE16: select bit picks alternate table
// RULE17: alternate table follows primary, same layout
// RULE18: vector 117 at 0FEh, code at 200h
// RULE19: reset forces program counter to zero
// RULE20: software fills unused slots with reset handler
module rcv_top #(
  parameter int N_IRQ = rcv_pkg::NUM_IRQ,
  parameter int N_TRAP = rcv_pkg::NUM_TRAP,
  parameter int PIN_MIN = rcv_pkg::PIN_MIN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [rcv_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rcv_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [rcv_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_event,
  input wire logic brownout_event,
  input wire logic master_clear_pin_n,
  input wire logic trap_conflict_event,
  input wire logic illegal_access_event,
  input wire logic config_mismatch_event,
  input wire logic soft_reset_event,
  input wire logic watchdog_expiry_event,
  input wire logic sleep_instruction,
  input wire logic idle_instruction,
  input wire logic watchdog_clear_instruction,
  input wire logic [N_IRQ-1:0] irq_req,
  input wire logic [N_TRAP-1:0] trap_req,
  input wire logic core_ack,
  input wire logic core_return,
  output logic core_irq,
  output logic [rcv_pkg::PC_W-1:0] vector_addr,
  output logic vector_valid,
  output logic [rcv_pkg::IRQ_IDX_W-1:0] active_vector,
  output logic in_service,
  output logic [rcv_pkg::PC_W-1:0] pc_reset_value,
  output logic sys_reset_req
);
  import rcv_pkg::*;

  logic [15:0] cause_q;
  logic [15:0] cause_d;
  logic [15:0] intctl2_q;
  logic [N_IRQ*PRIO_W-1:0] prio_q;
  logic [15:0] sync_ev1_q;
  logic [15:0] sync_ev2_q;
  logic [15:0] sync_ev3_q;
  logic pin_pulse;
  rcv_state_t state_q;
  logic [1:0] cyc_q;
  logic [PC_W-1:0] vec_q;
  logic [IRQ_IDX_W-1:0] idx_q;
  logic any_irq;
  logic [IRQ_IDX_W-1:0] win_idx;
  logic [PRIO_W-1:0] win_prio;

  // Vector address: table base plus two per slot
  function automatic logic [PC_W-1:0] vec_of(
    input logic alt,
    input logic [IRQ_IDX_W-1:0] slot
  );
    logic [PC_W-1:0] base;
    base = alt ? ALT_IRQ0 : PRIMARY_IRQ0;
    return base + PC_W'({slot, 1'b0}); // RULE18
  endfunction

  function automatic logic [PC_W-1:0] trap_vec(
    input logic alt,
    input logic [IRQ_IDX_W-1:0] slot
  );
    logic [PC_W-1:0] base;
    base = alt ? (PRIMARY_BASE + TABLE_SPAN) : PRIMARY_BASE;
    return base + TRAP0_OFF + PC_W'({slot, 1'b0});
  endfunction

  rcv_pin_filter #(
    .MIN_CYCLES(PIN_MIN)
  ) u_pin (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .master_clear_pin_n(master_clear_pin_n),
    .pin_reset_pulse(pin_pulse)
  );

  rcv_arbiter #(
    .N(N_IRQ)
  ) u_arb (
    .req(irq_req),
    .prio(prio_q),
    .any(any_irq),
    .win_idx(win_idx),
    .win_prio(win_prio)
  );

  // Event inputs come from other reset logic, so synchronise them
  wire [15:0] ev_raw = {trap_conflict_event, illegal_access_event,
    config_mismatch_event, soft_reset_event, watchdog_expiry_event,
    sleep_instruction, idle_instruction, watchdog_clear_instruction,
    power_on_event, brownout_event, trap_req, 2'b00};
  wire [15:0] ev_rise = sync_ev2_q & ~sync_ev3_q;
  wire ev_trap = ev_rise[15];
  wire ev_ill = ev_rise[14];
  wire ev_cfg = ev_rise[13];
  wire ev_soft = ev_rise[12];
  wire ev_wdog = ev_rise[11];
  wire ev_sleep = ev_rise[10];
  wire ev_idle = ev_rise[9];
  wire ev_wclr = ev_rise[8];
  wire ev_por = ev_rise[7];
  wire ev_bor = ev_rise[6];
  wire [N_TRAP-1:0] trap_lvl = sync_ev2_q[5:2];

  // APB decode; zero wait states, unmapped reads zero with error
  wire apb_acc = psel && penable;
  wire apb_wr = apb_acc && pwrite;
  wire hit_cause = (paddr == OFF_CAUSE);
  wire hit_ctl = (paddr == OFF_INTCTL2);
  wire hit_stat = (paddr == OFF_STATUS);
  wire hit_prio = (paddr >= OFF_PRIO_BASE) &&
    (paddr < OFF_PRIO_BASE + ADDR_W'(4 * N_IRQ)) && (paddr[1:0] == 2'b00);
  wire [ADDR_W-1:0] prio_off = paddr - OFF_PRIO_BASE;
  wire [IRQ_IDX_W-1:0] prio_sel = prio_off[IRQ_IDX_W+1:2];
  wire mapped = hit_cause || hit_ctl || hit_stat || hit_prio;
  wire [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire wr_cause = apb_wr && hit_cause;
  wire alt_sel = intctl2_q[BIT_ALT_SEL]; // RULE16

  wire [15:0] hw_set =
    (ev_trap ? (16'h0001 << BIT_TRAP) : 16'h0000) | // RULE4
    (ev_ill ? (16'h0001 << BIT_ILLEGAL) : 16'h0000) | // RULE4
    (ev_cfg ? (16'h0001 << BIT_CFG) : 16'h0000) | // RULE4
    (ev_soft ? (16'h0001 << BIT_SOFT) : 16'h0000) | // RULE4
    (ev_wdog ? (16'h0001 << BIT_WDOG) : 16'h0000) | // RULE5
    (ev_sleep ? (16'h0001 << BIT_SLEEP) : 16'h0000) | // RULE6
    (ev_idle ? (16'h0001 << BIT_IDLE) : 16'h0000) | // RULE6
    (pin_pulse ? (16'h0001 << BIT_PIN) : 16'h0000) | // RULE8
    (ev_por ? 16'h0003 : 16'h0000) | // RULE7
    (ev_bor ? (16'h0001 << BIT_BROWN) : 16'h0000); // RULE7
  // Power-on clears everything except power and brown bits; brown-out also keeps the pin bit
  wire [15:0] bor_clr = 16'hC25C;
  wire [15:0] por_clr = 16'hC2DC;
  wire [15:0] hw_clr =
    (ev_por ? por_clr : 16'h0000) | // RULE6
    (ev_bor ? bor_clr : 16'h0000) | // RULE4
    ((ev_sleep || ev_idle || ev_wclr) ?
      (16'h0001 << BIT_WDOG) : 16'h0000); // RULE5

  // Software write first, then hardware clear, then hardware set wins
  always_comb
  begin
    cause_d = cause_q;
    if (wr_cause)
      cause_d = (cause_q & ~wmask) | (pwdata[15:0] & wmask); // RULE3
    cause_d = (cause_d & ~hw_clr) | hw_set;
    cause_d = cause_d & CAUSE_MASK;
  end

  // Status packs the state, the pending flag and the last slot; only
  // six slot bits fit, enough for the slots this variant implements
  wire [15:0] status_word = {7'h00, state_q, any_irq, idx_q[5:0]};
  wire [15:0] rd_word = hit_cause ? cause_q : // RULE1
    hit_ctl ? intctl2_q :
    hit_stat ? status_word :
    hit_prio ? {13'h0000, prio_q[prio_sel*PRIO_W +: PRIO_W]} : 16'h0000;

  // Register state and APB answer; the cause register keeps its
  // contents across core resets, as only this block's rst_n clears it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cause_q <= CAUSE_RST;
      intctl2_q <= INTCTL2_RST;
      prio_q <= {N_IRQ{PRIO_RST}};
      sync_ev1_q <= '0;
      sync_ev2_q <= '0;
      sync_ev3_q <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      sync_ev1_q <= ev_raw;
      sync_ev2_q <= sync_ev1_q;
      sync_ev3_q <= sync_ev2_q;
      cause_q <= cause_d;
      if (apb_wr && hit_ctl && pstrb[1])
        intctl2_q[BIT_ALT_SEL] <= pwdata[BIT_ALT_SEL];
      if (apb_wr && hit_prio && pstrb[0]) // RULE10
        prio_q[prio_sel*PRIO_W +: PRIO_W] <= pwdata[PRIO_W-1:0];
      // Answer registered at setup, so a write lands at the access edge
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? {16'h0000, rd_word} : '0;
    end
  end

  // Any pending hard trap outranks every maskable source
  wire any_trap = |trap_lvl; // RULE15
  logic [IRQ_IDX_W-1:0] trap_idx;
  always_comb
  begin
    trap_idx = '0;
    for (int t = N_TRAP - 1; t >= 0; t--)
      if (trap_lvl[t])
        trap_idx = IRQ_IDX_W'(t); // RULE14
  end
  // Traps bypass the priority registers, so software cannot mask them
  wire take = any_trap || any_irq; // RULE9
  wire [PC_W-1:0] next_vec = any_trap ? trap_vec(alt_sel, trap_idx) :
    vec_of(alt_sel, win_idx); // RULE12 RULE17
  wire [IRQ_IDX_W-1:0] next_idx = any_trap ? trap_idx :
    IRQ_IDX_W'(win_idx + IRQ_IDX_W'(TRAP_VECTORS)); // RULE13

  // Entry and return each last a fixed count regardless of source
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      cyc_q <= '0;
      vec_q <= RESET_PC;
      idx_q <= '0;
      core_irq <= 1'b0;
      vector_addr <= RESET_PC;
      vector_valid <= 1'b0;
      active_vector <= '0;
      in_service <= 1'b0;
      pc_reset_value <= RESET_PC; // RULE19
      sys_reset_req <= 1'b0;
    end
    else
    begin
      core_irq <= take && (state_q == ST_IDLE); // RULE9
      vector_valid <= 1'b0;
      sys_reset_req <= ev_trap || ev_ill || ev_cfg || ev_soft ||
        ev_wdog || pin_pulse;
      pc_reset_value <= RESET_PC; // RULE19
      unique case (state_q)
        ST_IDLE:
          if (take && core_ack)
          begin
            state_q <= ST_ENTRY;
            cyc_q <= '0;
            vec_q <= next_vec;
            idx_q <= next_idx;
          end
        ST_ENTRY:
          if (cyc_q == 2'(ENTRY_CYCLES - 1)) // RULE11
          begin
            state_q <= ST_SERVE;
            vector_addr <= vec_q;
            vector_valid <= 1'b1;
            active_vector <= idx_q;
            in_service <= 1'b1;
          end
          else
            cyc_q <= cyc_q + 2'd1;
        ST_SERVE:
          if (core_return)
          begin
            state_q <= ST_RETURN;
            cyc_q <= '0;
          end
        ST_RETURN:
          if (cyc_q == 2'(RETURN_CYCLES - 1)) // RULE11
          begin
            state_q <= ST_IDLE;
            in_service <= 1'b0;
          end
          else
            cyc_q <= cyc_q + 2'd1;
      endcase
    end
  end
endmodule

// [rtl/rcv_pkg.sv]
// Package with constants for the reset-cause and vector-table block
package rcv_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PC_W = 24;
  localparam int NUM_IRQ = 21;
  localparam int NUM_TRAP = 4;
  localparam int NUM_LEVEL = 7;
  localparam int PRIO_W = 3;
  localparam int IRQ_IDX_W = 7;
  localparam int TOTAL_VECTORS = 126;
  localparam int TRAP_VECTORS = 8;
  localparam int IRQ_VECTORS = 118;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CAUSE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_INTCTL2 = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_PRIO_BASE = 12'h040;
  // Reset-cause bit positions
  localparam int BIT_TRAP = 15;
  localparam int BIT_ILLEGAL = 14;
  localparam int BIT_CFG = 9;
  localparam int BIT_PIN = 7;
  localparam int BIT_SOFT = 6;
  localparam int BIT_WDOG = 4;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_IDLE = 2;
  localparam int BIT_BROWN = 1;
  localparam int BIT_POWER = 0;
  localparam int BIT_ALT_SEL = 15;
  localparam logic [15:0] CAUSE_MASK = 16'hC2DF;
  localparam logic [15:0] CAUSE_RST = 16'h0000;
  localparam logic [15:0] INTCTL2_RST = 16'h0000;
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h4;
  // Vector addresses
  localparam logic [PC_W-1:0] PRIMARY_BASE = 24'h000004;
  localparam logic [PC_W-1:0] PRIMARY_IRQ0 = 24'h000014;
  localparam logic [PC_W-1:0] ALT_IRQ0 = 24'h000114;
  localparam logic [PC_W-1:0] PRIMARY_LAST = 24'h0000FE;
  localparam logic [PC_W-1:0] CODE_START = 24'h000200;
  localparam logic [PC_W-1:0] RESET_PC = 24'h000000;
  localparam logic [PC_W-1:0] TABLE_SPAN = 24'h000100;
  localparam logic [PC_W-1:0] TRAP0_OFF = 24'h000002;
  // Fixed entry and return latency
  localparam int ENTRY_CYCLES = 3;
  localparam int RETURN_CYCLES = 3;
  // Minimum master-clear pulse, in ns, and the cycles it needs
  localparam int CLK_PERIOD_NS = 4;
  localparam int PIN_MIN_NS = 2000;
  localparam int PIN_MIN_CYCLES = (PIN_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int PIN_CNT_W = 10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ENTRY = 2'b01,
    ST_SERVE = 2'b11,
    ST_RETURN = 2'b10
  } rcv_state_t;
endpackage

// [rtl/rcv_arbiter.sv]
// Priority arbiter picking the winning interrupt source
`timescale 1ns/1ps
module rcv_arbiter #(
  parameter int N = rcv_pkg::NUM_IRQ
) (
  input wire logic [N-1:0] req,
  input wire logic [N*rcv_pkg::PRIO_W-1:0] prio,
  output logic any,
  output logic [rcv_pkg::IRQ_IDX_W-1:0] win_idx,
  output logic [rcv_pkg::PRIO_W-1:0] win_prio
);
  import rcv_pkg::*;

  // Lowest index wins a tie, so the scan is strict greater-than
  always_comb
  begin
    any = 1'b0;
    win_idx = '0;
    win_prio = '0;
    for (int i = 0; i < N; i++)
    begin
      if (req[i] && prio[i*PRIO_W +: PRIO_W] != '0 &&
          prio[i*PRIO_W +: PRIO_W] > win_prio)
      begin
        any = 1'b1;
        win_idx = IRQ_IDX_W'(i);
        win_prio = prio[i*PRIO_W +: PRIO_W];
      end
    end
  end
endmodule

// [rtl/rcv_pin_filter.sv]
// Master-clear pin synchroniser and minimum pulse-width filter
`timescale 1ns/1ps
module rcv_pin_filter #(
  parameter int MIN_CYCLES = rcv_pkg::PIN_MIN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic master_clear_pin_n,
  output logic pin_reset_pulse
);
  import rcv_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic [PIN_CNT_W-1:0] cnt_q;
  logic fired_q;
  wire long_enough = (cnt_q >= PIN_CNT_W'(MIN_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      cnt_q <= '0;
      fired_q <= 1'b0;
      pin_reset_pulse <= 1'b0;
    end
    else
    begin
      sync1_q <= master_clear_pin_n;
      sync2_q <= sync1_q;
      pin_reset_pulse <= 1'b0;
      if (sync2_q)
      begin
        cnt_q <= '0;
        fired_q <= 1'b0;
      end
      else if (!long_enough)
        cnt_q <= cnt_q + PIN_CNT_W'(1);
      else if (!fired_q)
      begin
        fired_q <= 1'b1;
        pin_reset_pulse <= 1'b1;
      end
    end
  end
endmodule

// [tb/rcv_chk.sv]
// Assertion checker for the reset-cause and vector-table block
`timescale 1ns/1ps
module rcv_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [rcv_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rcv_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic core_irq,
  input wire logic core_ack,
  input wire logic core_return,
  input wire logic [rcv_pkg::PC_W-1:0] vector_addr,
  input wire logic vector_valid,
  input wire logic [rcv_pkg::IRQ_IDX_W-1:0] active_vector,
  input wire logic in_service,
  input wire logic [rcv_pkg::PC_W-1:0] pc_reset_value
);
  import rcv_pkg::*;
  logic alt_q;
  logic alt_d;
  wire logic wr_alt = psel && penable && pready && pwrite && pstrb[1]
    && paddr == OFF_INTCTL2;
  wire logic mapped = paddr == OFF_CAUSE || paddr == OFF_INTCTL2
    || paddr == OFF_STATUS || (paddr[1:0] == 2'b00
    && paddr >= OFF_PRIO_BASE && paddr < 12'h094);
  wire logic [7:0] slot2 = {active_vector, 1'b0};
  assign alt_d = wr_alt ? pwdata[BIT_ALT_SEL] : alt_q;
  // Shadow of the table select, so no internal probe is needed
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      alt_q <= 1'b0;
    else
      alt_q <= alt_d;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_entry;
    core_irq && core_ack;
  endsequence
  sequence s_leave;
    core_return && in_service;
  endsequence
  a_apb_answer:
    assert property (psel && !penable |=> pready) else $error("no answer");
  a_apb_refuse:
    assert property (pready |-> pslverr == !mapped) else $error("bad resp");
  a_entry_fixed:
    assert property (s_entry |=> !vector_valid [*3] ##1 vector_valid)
    else $error("entry latency differs");
  a_return_fixed:
    assert property (s_leave |=> in_service [*3] ##1 !in_service)
    else $error("return latency differs");
  a_fold_idle:
    assert property (core_irq |-> !in_service) else $error("irq in service");
  a_pc_zero:
    assert property (pc_reset_value == RESET_PC) else $error("pc not zero");
  a_irq_slot:
    assert property (vector_valid && active_vector >= 7'h08
      |-> vector_addr[7:0] == 8'h04 + slot2) else $error("irq vector");
  a_trap_slot:
    assert property (vector_valid && active_vector < 7'h08
      |-> vector_addr[7:0] == 8'h06 + slot2) else $error("trap vector");
  a_vec_range:
    assert property (vector_valid |-> active_vector < 7'h04
      || (active_vector >= 7'h08 && active_vector < 7'h1D))
    else $error("unimplemented source");
  a_alt_table:
    assert property (vector_valid |-> vector_addr[8] == alt_q
      && vector_addr[23:9] == 15'h0000) else $error("wrong table");
endmodule
bind rcv_top rcv_chk u_chk (
  .core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
  .pready, .pslverr, .core_irq, .core_ack, .core_return, .vector_addr,
  .vector_valid, .active_vector, .in_service, .pc_reset_value
);

// [tb/rcv_core_model.sv]
// Core model that accepts, serves and returns interrupts
`timescale 1ns/1ps
module rcv_core_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic core_irq,
  input wire logic vector_valid,
  input wire logic in_service,
  input wire logic [3:0] ack_wait,
  input wire logic [rcv_pkg::PC_W-1:0] vector_addr,
  output logic core_ack,
  output logic core_return,
  output int ent_lat,
  output int ret_lat,
  output int done_cnt,
  output logic [rcv_pkg::PC_W-1:0] handler
);
  import rcv_pkg::*;
  logic [PC_W-1:0] table_q [0:511];
  int ofs;
  int cyc = 0;
  int t0;
  // Software side of both tables: unused slots hold the default
  // handler that resets, so a stray vector fetches that address
  initial
    for (int a = 0; a < 512; a++)
    begin
      ofs = a % 256;
      table_q[a] = ((ofs >= 6 && ofs <= 12) ||
        (ofs >= 20 && ofs < 20 + 2 * NUM_IRQ)) ?
        CODE_START + PC_W'(256 + a) : CODE_START;
    end
  always @(posedge core_clk)
    cyc <= cyc + 1;
  // Ack and return are one-cycle pulses; a held ack would re-enter
  initial
  begin
    core_ack = 1'b0;
    core_return = 1'b0;
    done_cnt = 0;
    handler = '0;
    forever
    begin
      @(posedge core_clk);
      if (rst_n && core_irq)
      begin
        repeat (ack_wait) @(posedge core_clk);
        core_ack <= 1'b1;
        @(posedge core_clk);
        core_ack <= 1'b0;
        t0 = cyc;
        @(posedge core_clk iff vector_valid);
        ent_lat = cyc - t0;
        handler = table_q[vector_addr[8:0]];
        repeat (4) @(posedge core_clk);
        core_return <= 1'b1;
        @(posedge core_clk);
        core_return <= 1'b0;
        t0 = cyc;
        @(posedge core_clk iff !in_service);
        ret_lat = cyc - t0;
        done_cnt++;
      end
    end
  end
endmodule

// [tb/tb.sv]
// Self-checking bench for the reset-cause and vector-table block
`timescale 1ns/1ps
module tb;
  import rcv_pkg::*;
  localparam int EBIT [2:8] = '{BIT_TRAP, BIT_ILLEGAL, BIT_CFG, BIT_SOFT,
    BIT_WDOG, BIT_SLEEP, BIT_IDLE};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, err;
  logic [9:0] ev = '0;
  logic master_clear_pin_n = 1'b1;
  logic [NUM_IRQ-1:0] irq_req = '0;
  logic [NUM_TRAP-1:0] trap_req = '0;
  logic [3:0] ack_wait = 4'h0;
  logic core_ack, core_return, core_irq, vector_valid, in_service;
  logic [PC_W-1:0] vector_addr;
  logic [PC_W-1:0] pc_reset_value;
  logic [IRQ_IDX_W-1:0] active_vector;
  logic [DATA_W-1:0] rd;
  logic [PC_W-1:0] handler;
  logic sys_reset_req;
  logic [3:0] strb = 4'hF;
  int resets = 0;
  int ent_lat, ret_lat, done_cnt;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  always #2 core_clk = ~core_clk;
  // Short pin filter keeps the glitch and long-pulse cases quick
  rcv_top #(.PIN_MIN(4)) u_dut (
    .core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .power_on_event(ev[0]),
    .brownout_event(ev[1]), .master_clear_pin_n,
    .trap_conflict_event(ev[2]), .illegal_access_event(ev[3]),
    .config_mismatch_event(ev[4]), .soft_reset_event(ev[5]),
    .watchdog_expiry_event(ev[6]), .sleep_instruction(ev[7]),
    .idle_instruction(ev[8]), .watchdog_clear_instruction(ev[9]),
    .irq_req, .trap_req, .core_ack, .core_return, .core_irq, .vector_addr,
    .vector_valid, .active_vector, .in_service, .pc_reset_value,
    .sys_reset_req
  );
  rcv_core_model u_core (
    .core_clk, .rst_n, .core_irq, .vector_valid, .in_service, .ack_wait,
    .vector_addr, .core_ack, .core_return, .ent_lat, .ret_lat, .done_cnt,
    .handler
  );
  task automatic stop_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= strb;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(rd, exp);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    repeat (2) @(posedge core_clk);
    ev[i] <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic pin(input int n);
    master_clear_pin_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    master_clear_pin_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic serve(input logic [NUM_IRQ-1:0] r,
    input logic [NUM_TRAP-1:0] t, input logic [PC_W-1:0] ea,
    input logic [IRQ_IDX_W-1:0] av);
    int d = done_cnt;
    irq_req <= r;
    trap_req <= t;
    @(posedge core_clk iff vector_valid);
    irq_req <= '0;
    trap_req <= '0;
    chk(32'(vector_addr), 32'(ea));
    chk(32'(active_vector), 32'(av));
    wait (done_cnt != d);
    @(posedge core_clk);
    chk(ent_lat, ENTRY_CYCLES + 1);
    chk(ret_lat, RETURN_CYCLES + 1);
    chk(32'(handler), 32'(CODE_START + 24'h100 + ea));
  endtask
  always @(posedge core_clk)
    if (sys_reset_req === 1'b1)
      resets++;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk(32'(pc_reset_value), 32'h0);
    rchk(OFF_CAUSE, 32'h0);
    rchk(OFF_PRIO_BASE, 32'(PRIO_RST));
    apb(1'b1, 12'h00C, 32'hFFFF);
    chk(32'(err), 32'h1);
    for (int i = 2; i <= 8; i++)
    begin
      pulse(i);
      rchk(OFF_CAUSE, 32'h1 << EBIT[i]);
      apb(1'b1, OFF_CAUSE, 32'h0);
    end
    chk(resets, 5);
    pin(2);
    rchk(OFF_CAUSE, 32'h0);
    pin(10);
    rchk(OFF_CAUSE, 32'h80);
    chk(resets, 6);
    apb(1'b1, OFF_CAUSE, 32'h0);
    pulse(6);
    pulse(9);
    rchk(OFF_CAUSE, 32'h0);
    pulse(6);
    pulse(7);
    rchk(OFF_CAUSE, 32'h8);
    apb(1'b1, OFF_CAUSE, 32'(CAUSE_MASK));
    rchk(OFF_CAUSE, 32'(CAUSE_MASK));
    strb = 4'h2;
    apb(1'b1, OFF_CAUSE, 32'h0);
    strb = 4'hF;
    rchk(OFF_CAUSE, 32'hDF);
    pulse(1);
    rchk(OFF_CAUSE, 32'h83);
    pulse(0);
    rchk(OFF_CAUSE, 32'h3);
    serve(21'h000020, 4'h0, 24'h00001E, 7'h0D);
    ack_wait <= 4'h3;
    serve(21'h020008, 4'h0, 24'h00001A, 7'h0B);
    apb(1'b1, 12'h084, 32'h7);
    serve(21'h020008, 4'h0, 24'h000036, 7'h19);
    apb(1'b1, OFF_INTCTL2, 32'h8000);
    rchk(OFF_INTCTL2, 32'h8000);
    serve(21'h100000, 4'h0, 24'h00013C, 7'h1C);
    serve(21'h000001, 4'h5, 24'h000106, 7'h00);
    apb(1'b1, OFF_INTCTL2, 32'h0);
    serve(21'h100000, 4'h0, 24'h00003C, 7'h1C);
    rchk(OFF_STATUS, 32'h1C);
    stop_test();
  end
endmodule
